// ===== rtl/sldb_led_driver.sv
// Operation
// - ready lamp only after diagnostics pass
// - run lamp steady while solving logic
// - port 1 lamp shows port 1 traffic
// - port 2 lamp shows port 2 traffic
// - peer lamp shows peer network traffic
// - protect lamp follows memory protect switch
// - battery lamp when battery needs replacing
// - error lamp on peer network error
// - stack, config, loopback faults blink twice
// - no bus ownership blinks twice, own code
// - serial controller faults blink four times
// - command buffer faults blink four times
// - peer coprocessor faults blink four times
// - bad framing states blink four times
// - RAM address, self-test faults blink five
// - boot, flash, executive faults blink eight
// - code only on download port, lamp count
`timescale 1ns/100ps
module sldb_led_driver #(
  parameter int ON_CYC = sldb_pkg::BLINK_ON_CYC,
  parameter int OFF_CYC = sldb_pkg::BLINK_OFF_CYC,
  parameter int PAUSE_CYC = sldb_pkg::PAUSE_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic i_diag_pass,
  input wire logic i_running,
  input wire logic i_port1_act,
  input wire logic i_port2_act,
  input wire logic i_peer_act,
  input wire logic i_mem_protect,
  input wire logic i_batt_low,
  input wire logic i_peer_err,
  input wire logic [sldb_pkg::NUM_FAULTS-1:0] i_fault,
  output logic O_READY,
  output logic O_RUN,
  output logic O_PORT1,
  output logic O_PORT2,
  output logic O_PEER,
  output logic O_MEM_PRT,
  output logic O_BATT_LOW,
  output logic O_ERROR,
  output logic O_FAULT_VALID,
  output logic [sldb_pkg::CODE_W-1:0] O_FAULT_CODE
);
  localparam int CNT_W = 32;

  // refused at elaboration: a pause no longer than a gap cannot be told from it
  if (ON_CYC < 1 || OFF_CYC < 1 || PAUSE_CYC <= OFF_CYC) begin : g_bad_timing
    $error("bad blink timing");
  end

  // ************************************
  // pin synchronisation
  // ************************************
  sldb_pkg::sldb_status_t st_raw, st;
  assign st_raw = '{i_diag_pass, i_running, i_port1_act, i_port2_act, i_peer_act,
                    i_mem_protect, i_batt_low, i_peer_err};

  sldb_sync #(.W($bits(sldb_pkg::sldb_status_t))) u_sync (
    .I_CLK(I_CLK),
    .I_RESET_N(I_RESET_N),
    .i_d(st_raw),
    .o_q(st)
  );

  // ************************************
  // fault encoding
  // ************************************
  // lowest bit wins when several faults rise together
  function automatic sldb_pkg::sldb_fault_t encode(input logic [sldb_pkg::NUM_FAULTS-1:0] f);
    sldb_pkg::sldb_fault_t r;
    r = '{sldb_pkg::CODE_NONE, 4'h0};
    for (int k = sldb_pkg::NUM_FAULTS - 1; k >= 0; k--) begin
      if (f[k]) begin
        if (k <= sldb_pkg::F_LOOPBACK) begin
          r.blinks = sldb_pkg::BLINKS_2;
          case (k)
            sldb_pkg::F_RAM_SIZING: r.code = sldb_pkg::CODE_RAM_SIZING;
            sldb_pkg::F_RUN_OUT: r.code = sldb_pkg::CODE_RUN_OUT;
            sldb_pkg::F_CMD_STACK: r.code = sldb_pkg::CODE_CMD_STACK;
            sldb_pkg::F_MASTER_CFG: r.code = sldb_pkg::CODE_MASTER_CFG;
            default: r.code = sldb_pkg::CODE_LOOPBACK;
          endcase
        end else if (k == sldb_pkg::F_NOT_MASTER) begin
          r.blinks = sldb_pkg::BLINKS_2;
          r.code = sldb_pkg::CODE_NOT_MASTER;
        end else if (k < sldb_pkg::F_PEER0) begin
          r.blinks = sldb_pkg::BLINKS_4;
          case (k)
            sldb_pkg::F_UART_HW: r.code = sldb_pkg::CODE_UART_HW;
            sldb_pkg::F_UART_INT: r.code = sldb_pkg::CODE_UART_INT;
            sldb_pkg::F_CMD_OVF: r.code = sldb_pkg::CODE_CMD_OVF;
            sldb_pkg::F_CMD_ZERO: r.code = sldb_pkg::CODE_CMD_ZERO;
            default: r.code = sldb_pkg::CODE_CMD_ABORT;
          endcase
        end else if (k < sldb_pkg::F_FRAME0) begin
          r.blinks = sldb_pkg::BLINKS_4;
          r.code = sldb_pkg::CODE_PEER_BASE + 16'(k - sldb_pkg::F_PEER0);
        end else if (k < sldb_pkg::F_RAM_ADDR) begin
          r.blinks = sldb_pkg::BLINKS_4;
          r.code = sldb_pkg::CODE_FRAME_BASE + 16'(k - sldb_pkg::F_FRAME0);
        end else if (k < sldb_pkg::F_BOOT_ROM) begin
          r.blinks = sldb_pkg::BLINKS_5;
          r.code = (k == sldb_pkg::F_RAM_ADDR) ? sldb_pkg::CODE_RAM_ADDR
                                                : sldb_pkg::CODE_POST_MPU;
        end else begin
          r.blinks = sldb_pkg::BLINKS_8;
          case (k)
            sldb_pkg::F_BOOT_ROM: r.code = sldb_pkg::CODE_BOOT_ROM;
            sldb_pkg::F_FLASH: r.code = sldb_pkg::CODE_FLASH;
            default: r.code = sldb_pkg::CODE_EXECUTIVE_FIRMWARE_RET;
          endcase
        end
      end
    end
    return r;
  endfunction

  // ************************************
  // fault latch and blink sequencer
  // ************************************
  typedef enum logic [1:0] {SLDB_IDLE, SLDB_ON, SLDB_OFF, SLDB_PAUSE} sldb_state_t;

  sldb_state_t state_r, state_nxt;
  logic latched_r, latched_nxt;
  sldb_pkg::sldb_fault_t fault_r, fault_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [3:0] nblink_r, nblink_nxt;

  always_comb begin
    state_nxt = state_r;
    latched_nxt = latched_r;
    fault_nxt = fault_r;
    cnt_nxt = cnt_r;
    nblink_nxt = nblink_r;
    if (!latched_r && |i_fault) begin
      latched_nxt = 1'b1;
      fault_nxt = encode(i_fault);
      state_nxt = SLDB_ON;
      cnt_nxt = CNT_W'(ON_CYC - 1);
      nblink_nxt = 4'h1;
    end else begin
      case (state_r)
        SLDB_IDLE: begin
          state_nxt = SLDB_IDLE;
        end
        SLDB_ON: begin
          if (cnt_r == '0) begin
            if (nblink_r == fault_r.blinks) begin
              state_nxt = SLDB_PAUSE;
              cnt_nxt = CNT_W'(PAUSE_CYC - 1);
            end else begin
              state_nxt = SLDB_OFF;
              cnt_nxt = CNT_W'(OFF_CYC - 1);
            end
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        SLDB_OFF, SLDB_PAUSE: begin
          if (cnt_r == '0) begin
            state_nxt = SLDB_ON;
            cnt_nxt = CNT_W'(ON_CYC - 1);
            nblink_nxt = (state_r == SLDB_PAUSE) ? 4'h1 : nblink_r + 4'h1;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        default: state_nxt = SLDB_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_r <= SLDB_IDLE;
      latched_r <= 1'b0;
      fault_r <= '{sldb_pkg::CODE_NONE, 4'h0};
      cnt_r <= '0;
      nblink_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      latched_r <= latched_nxt;
      fault_r <= fault_nxt;
      cnt_r <= cnt_nxt;
      nblink_r <= nblink_nxt;
    end
  end

  // ************************************
  // lamp outputs
  // ************************************
  sldb_pkg::sldb_status_t lamp_r, lamp_nxt;
  logic run_r, run_nxt;
  logic fv_r, fv_nxt;
  logic [sldb_pkg::CODE_W-1:0] code_r, code_nxt;

  always_comb begin
    lamp_nxt.diag_pass = st.diag_pass;
    lamp_nxt.running = 1'b0;
    lamp_nxt.port1_act = st.port1_act;
    lamp_nxt.port2_act = st.port2_act;
    lamp_nxt.peer_act = st.peer_act;
    lamp_nxt.mem_protect = st.mem_protect;
    lamp_nxt.batt_low = st.batt_low;
    lamp_nxt.peer_err = st.peer_err;
    run_nxt = latched_nxt ? (state_nxt == SLDB_ON) : st.running;
    // code only on the download port
    fv_nxt = latched_nxt;
    code_nxt = fault_nxt.code;
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      lamp_r <= '0;
      run_r <= 1'b0;
      fv_r <= 1'b0;
      code_r <= '0;
    end else begin
      lamp_r <= lamp_nxt;
      run_r <= run_nxt;
      fv_r <= fv_nxt;
      code_r <= code_nxt;
    end
  end

  assign O_READY = lamp_r.diag_pass;
  assign O_RUN = run_r;
  assign O_PORT1 = lamp_r.port1_act;
  assign O_PORT2 = lamp_r.port2_act;
  assign O_PEER = lamp_r.peer_act;
  assign O_MEM_PRT = lamp_r.mem_protect;
  assign O_BATT_LOW = lamp_r.batt_low;
  assign O_ERROR = lamp_r.peer_err;
  assign O_FAULT_VALID = fv_r;
  assign O_FAULT_CODE = code_r;

  // ************************************
  // checks
  // ************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);

  sequence s_pause_held;
    state_r == SLDB_PAUSE ##1 state_r == SLDB_PAUSE;
  endsequence

  sequence s_fault_taken;
    $rose(latched_r);
  endsequence

  AST_READY_FOLLOWS: assert property ($stable(st.diag_pass)
      |=> O_READY == $past(st.diag_pass)) else $error("ready lamp wrong");
  AST_RUN_STEADY: assert property (!latched_r && !latched_nxt
      |=> O_RUN == $past(st.running)) else $error("run lamp not steady");
  AST_PORT1: assert property (##1 O_PORT1 == $past(st.port1_act))
      else $error("port 1 lamp wrong");
  AST_PORT2: assert property (##1 O_PORT2 == $past(st.port2_act))
      else $error("port 2 lamp wrong");
  AST_PEER: assert property (##1 O_PEER == $past(st.peer_act))
      else $error("peer lamp wrong");
  AST_MEMPRT: assert property (##1 O_MEM_PRT == $past(st.mem_protect))
      else $error("protect lamp wrong");
  AST_BATT: assert property (##1 O_BATT_LOW == $past(st.batt_low))
      else $error("battery lamp wrong");
  AST_ERR: assert property (##1 O_ERROR == $past(st.peer_err))
      else $error("error lamp wrong");
  AST_TWO_GROUP: assert property (latched_r && fault_r.code == sldb_pkg::CODE_LOOPBACK
      |-> fault_r.blinks == sldb_pkg::BLINKS_2) else $error("two blink group wrong");
  AST_NOT_MASTER: assert property ($rose(latched_r) && $past(i_fault[5:0]) == 6'h20
      |-> fault_r.code == sldb_pkg::CODE_NOT_MASTER && fault_r.blinks == sldb_pkg::BLINKS_2)
      else $error("ownership fault wrong");
  AST_FOUR_GROUP: assert property (latched_r && fault_r.code[15:8] == 8'h06
      |-> fault_r.blinks == sldb_pkg::BLINKS_4) else $error("four blink group wrong");
  AST_CMD_CODE: assert property ($rose(latched_r) && $past(i_fault[8:0]) == 9'h100
      |-> fault_r.code == sldb_pkg::CODE_CMD_OVF) else $error("command code wrong");
  AST_PEER_CODE: assert property ($rose(latched_r) && $past(i_fault[14:0]) == 15'h4000
      |-> fault_r.code == 16'h0617) else $error("peer code wrong");
  AST_FRAME_CODE: assert property ($rose(latched_r)
      && $past(i_fault[21:0]) == 22'h200000
      |-> fault_r.code == 16'h0625) else $error("framing code wrong");
  AST_FIVE_GROUP: assert property (latched_r && fault_r.code[15:8] == 8'h05
      |-> fault_r.blinks == sldb_pkg::BLINKS_5) else $error("five blink group wrong");
  AST_EIGHT_GROUP: assert property (latched_r && fault_r.code[15:8] == 8'h80
      |-> fault_r.blinks == sldb_pkg::BLINKS_8) else $error("eight blink group wrong");
  AST_CODE_HIDDEN: assert property (!O_FAULT_VALID |-> O_FAULT_CODE == 16'h0000)
      else $error("code shown without fault");
  AST_PAUSE_DARK: assert property (s_pause_held |-> !O_RUN)
      else $error("run lamp lit in pause");
  AST_LATCH_HOLD: assert property (latched_r |=> latched_r && $stable(fault_r))
      else $error("latched fault changed");
  AST_FIRST_BLINK: assert property (s_fault_taken |-> O_RUN && O_FAULT_VALID)
      else $error("first blink not shown with the fault");
endmodule // sldb_led_driver

// ===== rtl/sldb_pkg.sv
package sldb_pkg;

  // ************************************
  // fault codes, 16 bits, as held internally
  // ************************************
  localparam int CODE_W = 16;
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_RAM_SIZING = 16'h080b;
  localparam logic [15:0] CODE_RUN_OUT = 16'h080c;
  localparam logic [15:0] CODE_CMD_STACK = 16'h082e;
  localparam logic [15:0] CODE_NOT_MASTER = 16'h072a;
  localparam logic [15:0] CODE_MASTER_CFG = 16'h072b;
  localparam logic [15:0] CODE_LOOPBACK = 16'h072f;
  localparam logic [15:0] CODE_UART_HW = 16'h061e;
  localparam logic [15:0] CODE_UART_INT = 16'h061f;
  localparam logic [15:0] CODE_CMD_OVF = 16'h0607;
  localparam logic [15:0] CODE_CMD_ZERO = 16'h0608;
  localparam logic [15:0] CODE_CMD_ABORT = 16'h0609;
  localparam logic [15:0] CODE_PEER_BASE = 16'h0614;
  localparam logic [15:0] CODE_FRAME_BASE = 16'h0620;
  localparam logic [15:0] CODE_RAM_ADDR = 16'h0503;
  localparam logic [15:0] CODE_POST_MPU = 16'h052d;
  localparam logic [15:0] CODE_BOOT_ROM = 16'h8001;
  localparam logic [15:0] CODE_FLASH = 16'h8002;
  localparam logic [15:0] CODE_EXECUTIVE_FIRMWARE_RET = 16'h8003;

  // ************************************
  // blink counts per fault group
  // ************************************
  localparam logic [3:0] BLINKS_2 = 4'h2;
  localparam logic [3:0] BLINKS_4 = 4'h4;
  localparam logic [3:0] BLINKS_5 = 4'h5;
  localparam logic [3:0] BLINKS_8 = 4'h8;

  // ************************************
  // fault input vector bit positions
  // ************************************
  localparam int F_RAM_SIZING = 0;
  localparam int F_RUN_OUT = 1;
  localparam int F_CMD_STACK = 2;
  localparam int F_MASTER_CFG = 3;
  localparam int F_LOOPBACK = 4;
  localparam int F_NOT_MASTER = 5;
  localparam int F_UART_HW = 6;
  localparam int F_UART_INT = 7;
  localparam int F_CMD_OVF = 8;
  localparam int F_CMD_ZERO = 9;
  localparam int F_CMD_ABORT = 10;
  localparam int F_PEER0 = 11;
  localparam int F_FRAME0 = 16;
  localparam int F_RAM_ADDR = 22;
  localparam int F_POST_MPU = 23;
  localparam int F_BOOT_ROM = 24;
  localparam int F_FLASH = 25;
  localparam int F_EXECUTIVE_FIRMWARE_RET = 26;
  localparam int NUM_FAULTS = 27;

  // ************************************
  // blink timing
  // ************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int BLINK_ON_MS = 250;
  localparam int BLINK_OFF_MS = 250;
  localparam int PAUSE_MS = 1500;
  localparam int BLINK_ON_CYC = BLINK_ON_MS * (CLK_HZ / 1000);
  localparam int BLINK_OFF_CYC = BLINK_OFF_MS * (CLK_HZ / 1000);
  localparam int PAUSE_CYC = PAUSE_MS * (CLK_HZ / 1000);

  typedef struct packed {
    logic [15:0] code;
    logic [3:0] blinks;
  } sldb_fault_t;

  typedef struct packed {
    logic diag_pass;
    logic running;
    logic port1_act;
    logic port2_act;
    logic peer_act;
    logic mem_protect;
    logic batt_low;
    logic peer_err;
  } sldb_status_t;

endpackage

// ===== rtl/sldb_sync.sv
`timescale 1ns/100ps
module sldb_sync #(
  parameter int W = 8
) (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] s1_r, s2_r, s3_r, q_r;
  logic [W-1:0] q_nxt;

  // refused at elaboration: a zero-width bus has nothing to synchronise
  if (W < 1) begin : g_bad_width
    $error("sldb_sync width must be positive");
  end

  // ************************************
  // change taken once stages two and three agree
  // ************************************
  always_comb begin
    for (int k = 0; k < W; k++) begin
      q_nxt[k] = (s2_r[k] == s3_r[k]) ? s3_r[k] : q_r[k];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign o_q = q_r;
endmodule // sldb_sync

// ===== testbench/sldb_lamp_panel.sv
`timescale 1ns/100ps
// ************************************
// operator reading the run lamp
// ************************************
// a dark spell of PAUSE_MIN or more closes a group, as a person counting blinks would
module sldb_lamp_panel #(
  parameter int PAUSE_MIN = 5
) (
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  input wire logic i_run_lamp,
  output logic [7:0] o_groups,
  output logic [7:0] o_blinks,
  output logic [7:0] o_on_len,
  output logic [7:0] o_gap_len,
  output logic [7:0] o_pause_len
);
  logic [7:0] cnt_on;
  logic [7:0] cnt_dark;
  logic [7:0] seen;
  logic was_lit;

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      {o_groups, o_blinks, o_on_len, o_gap_len, o_pause_len} <= '0;
      {cnt_on, cnt_dark, seen} <= '0;
      was_lit <= 1'b0;
    end else begin
      was_lit <= i_run_lamp;
      if (i_run_lamp) begin
        cnt_on <= cnt_on + 8'h01;
        cnt_dark <= 8'h00;
        if (!was_lit) begin
          seen <= seen + 8'h01;
          if (cnt_dark >= 8'(PAUSE_MIN)) begin
            o_pause_len <= cnt_dark;
          end else if (seen != 8'h00) begin
            o_gap_len <= cnt_dark;
          end
        end
      end else begin
        // saturate so a long dark spell never wraps into a short one
        if (cnt_dark != 8'hff) begin
          cnt_dark <= cnt_dark + 8'h01;
        end
        cnt_on <= 8'h00;
        if (was_lit) begin
          o_on_len <= cnt_on;
        end
        if (cnt_dark == 8'(PAUSE_MIN - 1) && seen != 8'h00) begin
          o_blinks <= seen;
          o_groups <= o_groups + 8'h01;
          seen <= 8'h00;
        end
      end
    end
  end
endmodule // sldb_lamp_panel

// ===== testbench/tb_status_led_blink_code_driver.sv
`timescale 1ns/100ps
module tb_status_led_blink_code_driver;
  // short blink timing keeps the run small
  localparam int ON = 3;
  localparam int OFF = 2;
  localparam int PSE = 10;
  logic I_CLK;
  logic I_RESET_N;
  sldb_pkg::sldb_status_t st;
  logic [sldb_pkg::NUM_FAULTS-1:0] fault;
  logic [26:0] mask;
  logic [31:0] rng;
  int failures;
  int checks_done;
  int k;
  logic rdy, run, p1, p2, peer, mp, bl, er, fv;
  logic [15:0] code;
  logic [7:0] groups, blinks, on_len, gap_len, pause_len;
  logic [15:0] tbl [sldb_pkg::NUM_FAULTS] = '{16'h080b, 16'h080c, 16'h082e, 16'h072b, 16'h072f,
    sldb_pkg::CODE_NOT_MASTER, 16'h061e, 16'h061f, 16'h0607, 16'h0608, 16'h0609, 16'h0614,
    16'h0615, 16'h0616, 16'h0617, 16'h0618, 16'h0620, 16'h0621, 16'h0622, 16'h0623, 16'h0624,
    16'h0625, 16'h0503, 16'h052d, 16'h8001, 16'h8002, 16'h8003};

  sldb_led_driver #(.ON_CYC(ON), .OFF_CYC(OFF), .PAUSE_CYC(PSE)) DUT (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .i_diag_pass(st.diag_pass), .i_running(st.running),
    .i_port1_act(st.port1_act), .i_port2_act(st.port2_act), .i_peer_act(st.peer_act),
    .i_mem_protect(st.mem_protect), .i_batt_low(st.batt_low), .i_peer_err(st.peer_err),
    .i_fault(fault), .O_READY(rdy), .O_RUN(run), .O_PORT1(p1), .O_PORT2(p2), .O_PEER(peer),
    .O_MEM_PRT(mp), .O_BATT_LOW(bl), .O_ERROR(er), .O_FAULT_VALID(fv), .O_FAULT_CODE(code));

  sldb_lamp_panel #(.PAUSE_MIN(OFF + 3)) panel (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .i_run_lamp(run), .o_groups(groups),
    .o_blinks(blinks), .o_on_len(on_len), .o_gap_len(gap_len), .o_pause_len(pause_len));

  // ************************************
  // helpers
  // ************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  function automatic logic [7:0] exp_blinks(input int i);
    if (i <= sldb_pkg::F_NOT_MASTER) return 8'h02;
    if (i < sldb_pkg::F_RAM_ADDR) return 8'h04;
    if (i < sldb_pkg::F_BOOT_ROM) return 8'h05;
    return 8'h08;
  endfunction

  task automatic end_sim();
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic do_reset();
    I_RESET_N <= 1'b0;
    repeat (6) @(posedge I_CLK);
    I_RESET_N <= 1'b1;
    #1;
    chk("reset", 32'({rdy, run, p1, p2, peer, mp, bl, er, fv, code}), 32'h0);
    @(posedge I_CLK);
  endtask

  // ************************************
  // clock, watchdog, sequence
  // ************************************
  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end

  initial begin
    repeat (20000) @(posedge I_CLK);
    failures++;
    end_sim();
  end

  initial begin
    I_RESET_N = 1'b0;
    st = '0;
    fault = '0;
    rng = 32'd85;
    failures = 0;
    checks_done = 0;
    do_reset();
    // all lit and all dark first, then random levels; 5 edges of latency
    for (int n = 0; n < 24; n++) begin
      st <= (n == 0) ? 8'hff : (n == 1) ? 8'h00 : 8'(rnd());
      repeat (6) @(posedge I_CLK);
      #1;
      chk("lamps", 32'({rdy, run, p1, p2, peer, mp, bl, er}), 32'(st));
      @(posedge I_CLK);
    end
    // every fault, with random higher-index faults alongside; lowest index wins
    for (int i = 0; i < sldb_pkg::NUM_FAULTS; i++) begin
      @(posedge I_CLK);
      st <= 8'hff;
      do_reset();
      mask = (27'(rnd()) & ~((27'h2 << i) - 27'h1)) | (27'h1 << i);
      @(posedge I_CLK);
      fault <= mask;
      #1;
      chk("valid_early", 32'(fv), 32'h0);
      // the fault is taken at this edge and shows right after it
      @(posedge I_CLK);
      fault <= '0;
      #1;
      chk("code", 32'(code), 32'(tbl[i]));
      chk("run_first", 32'({fv, run}), 32'h3);
      k = 0;
      while (groups < 8'h02 && k < 300) begin
        @(posedge I_CLK);
        k++;
      end
      // a later fault must not replace the latched one
      fault <= '1;
      repeat (3) @(posedge I_CLK);
      fault <= '0;
      #1;
      chk("groups", 32'(groups), 32'h2);
      chk("blinks", 32'(blinks), 32'(exp_blinks(i)));
      chk("on_len", 32'(on_len), 32'(ON));
      if (exp_blinks(i) > 8'h01) chk("gap_len", 32'(gap_len), 32'(OFF));
      chk("pause_len", 32'(pause_len), 32'(PSE));
      chk("code_kept", 32'({fv, code}), 32'({1'b1, tbl[i]}));
    end
    end_sim();
  end
endmodule // tb_status_led_blink_code_driver
